/* core/acs_pkg.sv */
// Constants shared by the channel and setup register bank.
// Assumes a serial host in SPI mode 3 and a 100 MHz ref_clk.
//
// What this block does
// - With several channels on, scan ascends channel 0 to 3, then wraps.
// - Channels with chan_on clear are skipped and take no slot.
// - Each channel picks plus and minus pins, chan_on and profile_pick.
// - Channel register: reset 0x8001 on channel 0, 0x0001 on 1 to 3, fields at 15, 13:12, 9:5, 4:0.
// - Four setups of config, filter, gain and offset registers.
// - signed_coding: bipolar offset binary, or unipolar straight binary.
// - voltage_source_pick selects internal, external or supply reference.
// - Input and reference buffers switch on and off independently.
// - Setup config: reset 0x1000, fields at 12, 11..8, 7, 5:4.
// - Filter config: reset 0x0500, fields at 15, 11, 10:8, 6:5, 4:0.
// - Gain is 24-bit, loaded with a factory value, replaced by writes.
// - Offset is 24-bit, resets to 0x800000, replaced by writes.
// - Converter control holds mode, clock source and reference enable.
// - Converter control: reset 0x0000, fields at 15, 14, 13, 10:8, 6:4, 3:2.
// - Interface control: word length, CRC, status append, continuous read.
// - Command byte: bit 7 write gate, bit 6 direction, 5:0 address.
// - Part code at 0x07 is read only and ignores writes.
// - After reset and each access the port waits for a command byte.
// - 64 or more clocks with data-in high reset the whole device.
// - SPI mode 3: drive on falling edges, sample on rising edges.
package acs_pkg;
    localparam logic [5:0]  ADDR_CTRL   = 6'h01;
    localparam logic [5:0]  ADDR_LINK   = 6'h02;
    localparam logic [5:0]  ADDR_PART   = 6'h07;
    localparam logic [5:0]  ADDR_CHAN   = 6'h10;
    localparam logic [5:0]  ADDR_PCFG   = 6'h20;
    localparam logic [5:0]  ADDR_DCFG   = 6'h28;
    localparam logic [5:0]  ADDR_ZERO   = 6'h30;
    localparam logic [5:0]  ADDR_SCALE  = 6'h38;
    localparam logic [15:0] RST_CTRL    = 16'h0000;
    localparam logic [15:0] RST_LINK    = 16'h0000;
    localparam logic [15:0] RST_CHAN0   = 16'h8001;
    localparam logic [15:0] RST_CHANX   = 16'h0001;
    localparam logic [15:0] RST_PCFG    = 16'h1000;
    localparam logic [15:0] RST_DCFG    = 16'h0500;
    localparam logic [23:0] RST_ZERO    = 24'h800000;
    localparam logic [15:0] MASK_CTRL   = 16'he77c;
    localparam logic [15:0] MASK_LINK   = 16'h1fed;
    localparam logic [15:0] MASK_CHAN   = 16'hb3ff;
    localparam logic [15:0] MASK_PCFG   = 16'h1fb0;
    localparam logic [15:0] MASK_DCFG   = 16'h8f7f;
    localparam int          BIT_WGATE   = 7;
    localparam int          BIT_READ    = 6;
    localparam int          BIT_CHON    = 15;
    localparam int          RESET_ONES  = 64;
    localparam logic [6:0]  RESET_CNT_W = 7'h40;
endpackage

/* core/acs_regs.sv */
// Register bank and SPI mode 3 serial slave of the converter.
// Assumes host sclk is far slower than ref_clk and is sampled by it.
`timescale 1ns/1ns
module acs_regs #(
    parameter logic [15:0] PART_CODE  = 16'h00a5, // Arbitrary value.
    parameter logic [23:0] SCALE_INIT = 24'h555550 // Arbitrary factory value.
) (
    // Clock, reset and enable.
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        clk_en,
    // Serial pins.
    input  wire logic        sclk,
    input  wire logic        cs_n,
    input  wire logic        data_in,
    output logic             data_out,
    output logic             data_out_en,
    // Sequencer and active setup.
    input  wire logic        conv_done,
    output logic [1:0]       active_chan,
    output logic [15:0]      active_chan_reg,
    output logic [15:0]      active_pcfg,
    output logic [15:0]      active_dcfg,
    output logic [23:0]      active_zero,
    output logic [23:0]      active_scale,
    output logic [15:0]      ctrl_reg,
    output logic [15:0]      link_reg
);
    typedef enum logic [1:0] {
        ACS_CMD  = 2'b00,
        ACS_DATA = 2'b01
    } acs_state_t;

    // Pin synchronisers, three stages each.
    // They reset to the idle levels, so no false edge follows reset.
    logic [2:0] sclk_s, cs_s, din_s;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sclk_s <= 3'h7;
            cs_s   <= 3'h7;
            din_s  <= 3'h0;
        end else if (clk_en) begin
            sclk_s <= {sclk_s[1:0], sclk};
            cs_s   <= {cs_s[1:0], cs_n};
            din_s  <= {din_s[1:0], data_in};
        end
    end

    // Agreed levels; a change counts once stages two and three agree.
    logic sclk_lv, cs_lv, din_lv;
    logic next_sclk_lv, next_cs_lv, next_din_lv;
    always_comb begin
        next_sclk_lv = (sclk_s[1] == sclk_s[2]) ? sclk_s[2] : sclk_lv;
        next_cs_lv   = (cs_s[1] == cs_s[2]) ? cs_s[2] : cs_lv;
        next_din_lv  = (din_s[1] == din_s[2]) ? din_s[2] : din_lv;
    end
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sclk_lv <= 1'b1;
            cs_lv   <= 1'b1;
            din_lv  <= 1'b0;
        end else if (clk_en) begin
            sclk_lv <= next_sclk_lv;
            cs_lv   <= next_cs_lv;
            din_lv  <= next_din_lv;
        end
    end
    logic rise, fall;
    assign rise = next_sclk_lv & ~sclk_lv;
    assign fall = ~next_sclk_lv & sclk_lv;

    // Register storage.
    logic [15:0] ctrl, link;
    logic [15:0] chan [4];
    logic [15:0] pcfg [4];
    logic [15:0] dcfg [4];
    logic [23:0] zero [4];
    logic [23:0] scale [4];

    // Serial engine state.
    acs_state_t  state, next_state;
    logic [23:0] sh, next_sh;
    logic [4:0]  cnt, next_cnt;
    logic [4:0]  len, next_len;
    logic [5:0]  addr, next_addr;
    logic        rd, next_rd;
    logic [6:0]  ones, next_ones;
    logic        dout, next_dout;
    logic        wr_stb, next_wr_stb;
    logic        soft_rst;

    // Width of each register; eight marks an unmapped address.
    function automatic logic [4:0] reg_len(input logic [5:0] a);
        if (a == acs_pkg::ADDR_CTRL || a == acs_pkg::ADDR_LINK ||
            a == acs_pkg::ADDR_PART || a[5:2] == acs_pkg::ADDR_CHAN[5:2] ||
            a[5:2] == acs_pkg::ADDR_PCFG[5:2] ||
            a[5:2] == acs_pkg::ADDR_DCFG[5:2])
            reg_len = 5'd16;
        else if (a[5:2] == acs_pkg::ADDR_ZERO[5:2] ||
                 a[5:2] == acs_pkg::ADDR_SCALE[5:2])
            reg_len = 5'd24;
        else
            reg_len = 5'd8;
    endfunction

    // Read value, left aligned for MSB-first shifting.
    function automatic logic [23:0] rd_val(input logic [5:0] a);
        logic [1:0] i;
        i = a[1:0];
        rd_val = 24'h000000;
        if (a == acs_pkg::ADDR_CTRL)
            rd_val = {ctrl, 8'h00};
        else if (a == acs_pkg::ADDR_LINK)
            rd_val = {link, 8'h00};
        else if (a == acs_pkg::ADDR_PART)
            rd_val = {PART_CODE, 8'h00};
        else if (a[5:2] == acs_pkg::ADDR_CHAN[5:2])
            rd_val = {chan[i], 8'h00};
        else if (a[5:2] == acs_pkg::ADDR_PCFG[5:2])
            rd_val = {pcfg[i], 8'h00};
        else if (a[5:2] == acs_pkg::ADDR_DCFG[5:2])
            rd_val = {dcfg[i], 8'h00};
        else if (a[5:2] == acs_pkg::ADDR_ZERO[5:2])
            rd_val = zero[i];
        else if (a[5:2] == acs_pkg::ADDR_SCALE[5:2])
            rd_val = scale[i];
    endfunction

    // Command bit that holds the write gate once seven bits are in.
    localparam int BIT_FIX = acs_pkg::BIT_WGATE - 1;

    // Serial next state: command byte first, then the data phase.
    always_comb begin
        next_state  = state;
        next_sh     = sh;
        next_cnt    = cnt;
        next_len    = len;
        next_addr   = addr;
        next_rd     = rd;
        next_ones   = ones;
        next_dout   = dout;
        next_wr_stb = 1'b0;
        if (cs_lv) begin
            next_state = ACS_CMD;
            next_cnt   = 5'd0;
            next_dout  = 1'b1;
        end else if (rise) begin
            // Count data-in ones; a zero restarts the count.
            if (din_lv && ones < acs_pkg::RESET_CNT_W)
                next_ones = ones + 7'd1;
            else if (!din_lv)
                next_ones = 7'd0;
            next_cnt = cnt + 5'd1;
            next_sh  = {sh[22:0], din_lv};
            if (state == ACS_CMD && cnt == 5'd7) begin
                next_cnt = 5'd0;
                // A set write gate bit is not a command; stay waiting.
                if (!sh[BIT_FIX]) begin
                    next_addr  = {sh[4:0], din_lv};
                    next_rd    = sh[acs_pkg::BIT_READ - 1];
                    next_len   = reg_len({sh[4:0], din_lv});
                    next_state = ACS_DATA;
                    if (sh[acs_pkg::BIT_READ - 1])
                        next_sh = rd_val({sh[4:0], din_lv});
                end
            end else if (state == ACS_DATA && next_cnt == len) begin
                next_state  = ACS_CMD;
                next_cnt    = 5'd0;
                next_wr_stb = !rd;
            end
        end else if (fall && state == ACS_DATA && rd) begin
            next_dout = sh[23];
        end else if (fall) begin
            next_dout = 1'b1;
        end
    end
    // Sixty-four ones in a row wipe the bank, even across frames.
    assign soft_rst = (ones == acs_pkg::RESET_CNT_W);

    always_ff @(posedge ref_clk) begin
        if (rst || (clk_en && soft_rst)) begin
            state  <= ACS_CMD;
            sh     <= 24'h000000;
            cnt    <= 5'd0;
            len    <= 5'd8;
            addr   <= 6'h00;
            rd     <= 1'b0;
            ones   <= 7'd0;
            dout   <= 1'b1;
            wr_stb <= 1'b0;
        end else if (clk_en) begin
            state  <= next_state;
            sh     <= next_sh;
            cnt    <= next_cnt;
            len    <= next_len;
            addr   <= next_addr;
            rd     <= next_rd;
            ones   <= next_ones;
            dout   <= next_dout;
            wr_stb <= next_wr_stb;
        end
    end

    // Register writes land in the cycle after the last data bit.
    always_ff @(posedge ref_clk) begin
        if (rst || (clk_en && soft_rst)) begin
            ctrl <= acs_pkg::RST_CTRL;
            link <= acs_pkg::RST_LINK;
        end else if (clk_en && wr_stb) begin
            if (addr == acs_pkg::ADDR_CTRL)
                ctrl <= sh[15:0] & acs_pkg::MASK_CTRL;
            if (addr == acs_pkg::ADDR_LINK)
                link <= sh[15:0] & acs_pkg::MASK_LINK;
        end
    end

    // Per setup and per channel storage.
    for (genvar g = 0; g < 4; g++) begin : g_set
        always_ff @(posedge ref_clk) begin
            if (rst || (clk_en && soft_rst)) begin
                chan[g]  <= (g == 0) ? acs_pkg::RST_CHAN0
                                     : acs_pkg::RST_CHANX;
                pcfg[g]  <= acs_pkg::RST_PCFG;
                dcfg[g]  <= acs_pkg::RST_DCFG;
                zero[g]  <= acs_pkg::RST_ZERO;
                scale[g] <= SCALE_INIT;
            end else if (clk_en && wr_stb && addr[1:0] == 2'(g)) begin
                if (addr[5:2] == acs_pkg::ADDR_CHAN[5:2])
                    chan[g] <= sh[15:0] & acs_pkg::MASK_CHAN;
                if (addr[5:2] == acs_pkg::ADDR_PCFG[5:2])
                    pcfg[g] <= sh[15:0] & acs_pkg::MASK_PCFG;
                if (addr[5:2] == acs_pkg::ADDR_DCFG[5:2])
                    dcfg[g] <= sh[15:0] & acs_pkg::MASK_DCFG;
                if (addr[5:2] == acs_pkg::ADDR_ZERO[5:2])
                    zero[g] <= sh;
                if (addr[5:2] == acs_pkg::ADDR_SCALE[5:2])
                    scale[g] <= sh;
            end
        end
    end

    // Sequencer: next enabled channel above the current, else lowest.
    logic [1:0] cur, next_cur;
    logic [3:0] on_mask;
    always_comb begin
        logic found;
        found = 1'b0;
        on_mask  = {chan[3][acs_pkg::BIT_CHON], chan[2][acs_pkg::BIT_CHON],
                    chan[1][acs_pkg::BIT_CHON], chan[0][acs_pkg::BIT_CHON]};
        next_cur = cur;
        if (conv_done || !on_mask[cur]) begin
            for (int k = 1; k < 4; k++) begin
                if (!found && on_mask[2'(cur + 2'(k))]) begin
                    found    = 1'b1;
                    next_cur = 2'(cur + 2'(k));
                end
            end
        end
    end
    always_ff @(posedge ref_clk) begin
        if (rst || (clk_en && soft_rst))
            cur <= 2'd0;
        else if (clk_en)
            cur <= next_cur;
    end

    // Registered outputs.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            active_chan     <= 2'd0;
            active_chan_reg <= acs_pkg::RST_CHAN0;
            active_pcfg     <= acs_pkg::RST_PCFG;
            active_dcfg     <= acs_pkg::RST_DCFG;
            active_zero     <= acs_pkg::RST_ZERO;
            active_scale    <= SCALE_INIT;
            ctrl_reg        <= acs_pkg::RST_CTRL;
            link_reg        <= acs_pkg::RST_LINK;
            data_out        <= 1'b1;
            data_out_en     <= 1'b0;
        end else if (clk_en) begin
            active_chan     <= cur;
            active_chan_reg <= chan[cur];
            active_pcfg     <= pcfg[chan[cur][13:12]];
            active_dcfg     <= dcfg[chan[cur][13:12]];
            active_zero     <= zero[chan[cur][13:12]];
            active_scale    <= scale[chan[cur][13:12]];
            ctrl_reg        <= ctrl;
            link_reg        <= link;
            data_out        <= dout;
            data_out_en     <= ~cs_lv;
        end
    end

    // Reset and serial reset; the outputs follow one cycle later.
    chan_reset_a: assert property (@(posedge ref_clk)
        rst |=> active_chan_reg == acs_pkg::RST_CHAN0)
        else $error("Channel register reset wrong.");
    soft_reset_a: assert property (@(posedge ref_clk)
        disable iff (rst) clk_en && soft_rst |=> ctrl == acs_pkg::RST_CTRL)
        else $error("Serial reset did not clear control.");
    soft_chan_a: assert property (@(posedge ref_clk)
        disable iff (rst) clk_en && soft_rst |=>
            chan[0] == acs_pkg::RST_CHAN0 && zero[3] == acs_pkg::RST_ZERO)
        else $error("Serial reset did not clear the setups.");

    // Serial port: the read load, the write gate, the idle state.
    part_read_a: assert property (@(posedge ref_clk)
        disable iff (rst)
        $rose(state == ACS_DATA) && rd && addr == acs_pkg::ADDR_PART
            |-> sh == {PART_CODE, 8'h00})
        else $error("Part code read loaded a wrong value.");
    gate_ignore_a: assert property (@(posedge ref_clk)
        disable iff (rst)
        clk_en && rise && !cs_lv && state == ACS_CMD && cnt == 5'd7 &&
            sh[BIT_FIX] |=> state == ACS_CMD)
        else $error("Command with the write gate set was taken.");
    cmd_wait_a: assert property (@(posedge ref_clk)
        disable iff (rst) clk_en && cs_lv |=> state == ACS_CMD)
        else $error("Port not waiting for command.");
    write_end_a: assert property (@(posedge ref_clk)
        disable iff (rst) wr_stb |-> state == ACS_CMD && !rd)
        else $error("Write strobe outside a write end.");
    // The enable drops in the cycle after the deselect is agreed.
    out_idle_a: assert property (@(posedge ref_clk)
        disable iff (rst) clk_en && cs_lv |=> !data_out_en)
        else $error("Output enabled while deselected.");

    // Register contents and the scan order.
    chan_mask_a: assert property (@(posedge ref_clk)
        disable iff (rst) (chan[1] & ~acs_pkg::MASK_CHAN) == 16'h0000)
        else $error("Reserved channel bits set.");
    // A write that lands between the two samples excuses the check.
    skip_off_a: assert property (@(posedge ref_clk)
        disable iff (rst)
        clk_en && on_mask != 4'h0 ##1 $stable(on_mask) |-> on_mask[cur])
        else $error("Sequencer sits on a disabled channel.");
    scan_wrap_a: assert property (@(posedge ref_clk)
        disable iff (rst)
        clk_en && conv_done && cur == 2'd3 && on_mask[0] |=> cur == 2'd0)
        else $error("Sequencer did not wrap to channel zero.");

    // Main scenarios.
    seq_step_c: cover property (@(posedge ref_clk) disable iff (rst)
        conv_done && cur == 2'd3 ##1 cur == 2'd0);
    write_c: cover property (@(posedge ref_clk) disable iff (rst) wr_stb);
    read_c: cover property (@(posedge ref_clk) disable iff (rst)
        $rose(state == ACS_DATA) && rd);
    soft_c: cover property (@(posedge ref_clk) disable iff (rst) soft_rst);
endmodule // acs_regs

/* verif/acs_host.sv */
// Host model: serial master in SPI mode 3 for the register bank.
// Assumes the bench calls one task at a time; the clock runs only in frames.
`timescale 1ns/1ns
module acs_host (
    // Serial pins.
    output logic      sclk,
    output logic      cs_n,
    output logic      data_in,
    input  wire logic data_out
);
    // Idle state: clock high, device deselected.
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        data_in = 1'b1;
    end

    // One bit of a 125 ns link clock: drive on fall, sample on rise.
    task automatic bit_cycle(input logic d, output logic q);
        sclk = 1'b0;
        data_in = d;
        #62;
        sclk = 1'b1;
        q = data_out;
        #63;
    endtask

    // Command byte, then n data bits MSB first; a short n aborts the access.
    task automatic frame(input logic [7:0] cmd, input int n,
                         input logic [23:0] wd, output logic [23:0] rd);
        logic [31:0] sh;
        logic        q;
        sh = {cmd, wd << (24 - n)};
        rd = 24'h0;
        cs_n = 1'b0;
        #63;
        for (int i = 0; i < 8 + n; i++) begin
            bit_cycle(sh[31 - i], q);
            if (i >= 8)
                rd = {rd[22:0], q};
        end
        // A released line must not keep showing its last value.
        data_in = ~data_in;
        cs_n = 1'b1;
        #250;
    endtask

    // Sixty-four clocks with data-in high reset the whole device.
    task automatic wipe();
        logic q;
        cs_n = 1'b0;
        #63;
        repeat (64) bit_cycle(1'b1, q);
        cs_n = 1'b1;
        #250;
    endtask
endmodule // acs_host

/* verif/acs_regs_tb.sv */
// Self-checking bench of the register bank, driven by a serial host model.
// Assumes the package and both modules are compiled before this file.
`timescale 1ns/1ns
module acs_regs_tb;
    localparam logic [15:0] PART_V  = 16'h3c5a;   // Arbitrary value.
    localparam logic [23:0] SCALE_V = 24'h5a1230; // Arbitrary value.
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        clk_en = 1'b1;
    logic        conv_done = 1'b0;
    logic        sclk, cs_n, data_in, data_out, data_out_en;
    logic [1:0]  active_chan;
    logic [15:0] active_chan_reg, active_pcfg, active_dcfg, ctrl_reg, link_reg;
    logic [23:0] active_zero, active_scale, rd, d;
    logic [23:0] shadow [64];
    logic [3:0]  pats [5];
    int          err_total = 0;
    int          n_compared = 0;

    always #5 ref_clk = ~ref_clk;

    acs_regs #(.PART_CODE(PART_V), .SCALE_INIT(SCALE_V)) acs_regs_inst (
        .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .sclk(sclk),
        .cs_n(cs_n), .data_in(data_in), .data_out(data_out),
        .data_out_en(data_out_en), .conv_done(conv_done),
        .active_chan(active_chan), .active_chan_reg(active_chan_reg),
        .active_pcfg(active_pcfg), .active_dcfg(active_dcfg),
        .active_zero(active_zero), .active_scale(active_scale),
        .ctrl_reg(ctrl_reg), .link_reg(link_reg));
    acs_host acs_host_inst (.sclk(sclk), .cs_n(cs_n), .data_in(data_in),
        .data_out(data_out));

    // Data bits of a register, 0 where nothing is mapped.
    function automatic int width_of(input logic [5:0] a);
        case (a[5:2])
            4'h4, 4'h8, 4'ha: return 16;
            4'hc, 4'he: return 24;
            default: return (a == 6'h01 || a == 6'h02 || a == 6'h07) ? 16 : 0;
        endcase
    endfunction

    // Writable bits; reserved and read-only bits stay out.
    function automatic logic [23:0] mask_of(input logic [5:0] a);
        case (a[5:2])
            4'h4: return 24'h00b3ff;
            4'h8: return 24'h001fb0;
            4'ha: return 24'h008f7f;
            4'hc, 4'he: return 24'hffffff;
            default: return (a == 6'h01) ? 24'h00e77c :
                (a == 6'h02) ? {8'h00, acs_pkg::MASK_LINK} : 24'h0;
        endcase
    endfunction

    // Value each register holds after either kind of reset.
    function automatic logic [23:0] reset_of(input logic [5:0] a);
        case (a[5:2])
            4'h4: return (a[1:0] == 2'd0) ? 24'h008001 : 24'h000001;
            4'h8: return 24'h001000;
            4'ha: return 24'h000500;
            4'hc: return 24'h800000;
            4'he: return SCALE_V;
            default: return (a == 6'h07) ? {8'h00, PART_V} : 24'h0;
        endcase
    endfunction

    // Next enabled channel above cur, wrapping to the lowest.
    function automatic logic [1:0] next_on(input logic [1:0] cur);
        logic [1:0] c;
        c = cur;
        for (int k = 0; k < 4; k++) begin
            c = c + 2'd1;
            if (shadow[{4'h4, c}][15] === 1'b1)
                return c;
        end
        return cur;
    endfunction

    task automatic chk(input logic [23:0] got, input logic [23:0] want,
                       input string what);
        n_compared++;
        if (got !== want) begin
            err_total++;
            $display("unexpected at %0t: %s got %h want %h", $time, what,
                     got, want);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [23:0] v);
        acs_host_inst.frame({2'b00, a}, (width_of(a) == 0) ? 8 : width_of(a),
                            v, rd);
        shadow[a] = (shadow[a] & ~mask_of(a)) | (v & mask_of(a));
    endtask

    task automatic check_all();
        for (int a = 0; a < 64; a++) begin
            if (width_of(6'(a)) != 0) begin
                acs_host_inst.frame({2'b01, 6'(a)}, width_of(6'(a)), 24'h0, rd);
                chk(rd, shadow[a], "register read");
            end
        end
    endtask

    // Outputs must follow the scanned channel and the setup it picks.
    task automatic port_chk(input logic [1:0] c);
        logic [1:0] p;
        p = shadow[{4'h4, c}][13:12];
        chk(24'(active_chan), 24'(c), "scan channel");
        chk(24'(active_chan_reg), shadow[{4'h4, c}], "channel");
        chk(24'(active_pcfg), shadow[{4'h8, p}], "setup config");
        chk(24'(active_dcfg), shadow[{4'ha, p}], "filter config");
        chk(active_zero, shadow[{4'hc, p}], "offset");
        chk(active_scale, shadow[{4'he, p}], "gain");
        chk(24'(ctrl_reg), shadow[6'h01], "control");
        chk(24'(link_reg), shadow[6'h02], "interface control");
        chk(24'({data_out_en, data_out}), 24'h1, "idle outputs");
    endtask

    task automatic done_test(input string name);
        $display("test %s done, %0d mismatches so far", name, err_total);
    endtask

    task automatic end_of_test();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Watchdog: the tests need a little over half of this span.
    initial begin
        #1_000_000;
        err_total++;
        $display("unexpected at %0t: run did not finish", $time);
        end_of_test();
    end

    // Main sequence; rst, clk_en and conv_done change on the falling edge of ref_clk.
    initial begin
        void'($urandom(32'h8bf2));
        pats = '{4'b1010, 4'b0001, 4'b1111, 4'b0110, 4'b0000};
        pats[4] = 4'($urandom) | 4'b1000;
        for (int a = 0; a < 64; a++)
            shadow[a] = reset_of(6'(a));
        repeat (8) @(negedge ref_clk);
        rst = 1'b0;
        repeat (4) @(negedge ref_clk);
        port_chk(2'd0);
        check_all();
        done_test("reset values");
        for (int a = 0; a < 64; a++)
            if (width_of(6'(a)) != 0)
                wr(6'(a), 24'($urandom));
        wr(6'h05, 24'($urandom));
        check_all();
        done_test("write and read back");
        fork
            acs_host_inst.frame(8'h10, 8, 24'($urandom), rd);
            begin
                #1000;
                chk(24'(data_out_en), 24'h1, "drive enable");
            end
        join
        acs_host_inst.frame(8'h81, 16, 24'h00ffff, rd);
        check_all();
        done_test("abort and write gate");
        for (int k = 0; k < 5; k++) begin
            for (int c = 0; c < 4; c++) begin
                d = 24'($urandom);
                d[15] = pats[k][c];
                wr({4'h4, 2'(c)}, d);
            end
            repeat (10) @(negedge ref_clk);
            chk(24'(shadow[{4'h4, active_chan}][15]), 24'h1, "scan start");
            d[1:0] = active_chan;
            for (int n = 0; n < 6; n++) begin
                d[1:0] = next_on(d[1:0]);
                @(negedge ref_clk) conv_done = 1'b1;
                @(negedge ref_clk) conv_done = 1'b0;
                repeat (4) @(negedge ref_clk);
                port_chk(d[1:0]);
            end
        end
        // A low clock enable must swallow a conversion-done pulse.
        @(negedge ref_clk) clk_en = 1'b0;
        conv_done = 1'b1;
        @(negedge ref_clk) conv_done = 1'b0;
        repeat (4) @(negedge ref_clk);
        port_chk(d[1:0]);
        clk_en = 1'b1;
        done_test("channel scan");
        acs_host_inst.wipe();
        for (int a = 0; a < 64; a++)
            shadow[a] = reset_of(6'(a));
        repeat (4) @(negedge ref_clk);
        port_chk(2'd0);
        check_all();
        done_test("serial reset");
        end_of_test();
    end
endmodule // acs_regs_tb
